// ==== rtl/ss_defines.svh ====
// Constants of the soft starter serial slave: timing, register map, codes.
// Assumes a 125 MHz core clock; included by bare name.
//
// Behaviour
// - The link runs at 9600 baud with 8 data bits, no parity, 1 stop bit.
// - A frame is address byte, function byte, data field, two check bytes.
// - Control word 0001 takes only function 06; 0002-0004 only function 03.
// - Parameters sit at 0256-0274 and take both function 03 and 06.
// - An unlisted register touches nothing and draws an exception reply.
// - The master runs, stops, watches and tunes the starter via registers.
// - The device is a multidrop slave and speaks only when asked.
// - With nonzero stop ramp, stop moves from bypass or the start phase to a ramp falling from full voltage.
// - The soft stop ends and cuts output at the initial start voltage.
// - Soft stop current limit is a percentage of the start current limit.
// - With zero stop ramp, stop drops bypass and thyristors at once.
// - Control bit 0 starts, bit 1 stops, bit 2 clears a fault, rest unused.
// - Status bits: 0 starting, 1 running, 2 soft stopping, 3 fault.
// - The current register holds average phase current times ten.
// - Exceptions echo address, set the function top bit, code 01/02/03.
`ifndef SS_DEFINES_SVH
`define SS_DEFINES_SVH

`define SS_CLK_HZ        125000000
`define SS_BAUD          9600
`define SS_BIT_CYC       (`SS_CLK_HZ / `SS_BAUD)
`define SS_GAP_BITS      35
`define SS_GAP_CYC       ((`SS_BIT_CYC + 1) * `SS_GAP_BITS)
`define SS_RAMP_UNIT_MS  10
`define SS_RAMP_UNIT_CYC (`SS_CLK_HZ / 1000 * `SS_RAMP_UNIT_MS)

`define SS_REG_CTRL      16'h0001
`define SS_REG_STAT      16'h0002
`define SS_REG_CURR      16'h0003
`define SS_REG_FAULT     16'h0004
`define SS_REG_PRM_FIRST 16'h0100
`define SS_REG_PRM_LAST  16'h0112
`define SS_PRM_NUM       19

`define SS_FC_READ       8'h03
`define SS_FC_WRITE      8'h06
`define SS_EXC_FLAG      8'h80
`define SS_EXC_FUNC      8'h01
`define SS_EXC_ADDR      8'h02
`define SS_EXC_VALUE     8'h03
`define SS_RD_BYTES      8'h02
`define SS_QTY_ONE       16'h0001

`define SS_LEN_REQ       4'h8
`define SS_LEN_OVF       4'h9
`define SS_LEN_RD        4'h5
`define SS_LEN_ECHO      4'h6
`define SS_LEN_EXC       4'h3
`define SS_LEN_CRC       4'h2

`define SS_CRC_INIT      16'hFFFF
`define SS_CRC_POLY      16'hA001

`define SS_CTL_START     0
`define SS_CTL_STOP      1
`define SS_CTL_RST       2

`define SS_PRM_STOP_RAMP 5'h02
`define SS_PRM_INIT_V    5'h03
`define SS_PRM_START_LIM 5'h06
`define SS_PRM_SOFT_LIM  5'h0F
`define SS_FULL_V        8'h64
`define SS_PCT_DIV       32'h00000064

`endif

// ==== rtl/ss_pkg.sv ====
// Types shared by the soft starter serial slave.
// Assumes nothing beyond the defines header.
package ss_pkg;
   typedef enum logic [1:0] {
      SS_MS_STOP     = 2'b00,
      SS_MS_STARTING = 2'b01,
      SS_MS_RUNNING  = 2'b10,
      SS_MS_SOFT     = 2'b11
   } ss_motor_t;

   typedef enum logic {
      SS_LK_RX = 1'b0,
      SS_LK_TX = 1'b1
   } ss_link_t;
endpackage

// ==== rtl/ss_uart_if.sv ====
// Byte link between the character engine and the frame logic.
// Assumes both ends run on the core clock.
`timescale 1ns/1ps
interface ss_uart_if;
   logic [7:0] rx_data;
   logic       rx_valid;
   logic       frame_end;
   logic [7:0] tx_data;
   logic       tx_start;
   logic       tx_busy;
   modport uart (output rx_data, output rx_valid, output frame_end,
                 input tx_data, input tx_start, output tx_busy);
   modport core (input rx_data, input rx_valid, input frame_end,
                 output tx_data, output tx_start, input tx_busy);
endinterface

// ==== rtl/ss_uart.sv ====
// Character engine: 8N1 receive and send, plus line silence detect.
// Assumes rxd_i is an asynchronous pin idling high.
`timescale 1ns/1ps
`include "ss_defines.svh"
module ss_uart #(
   parameter int BIT_CYC = `SS_BIT_CYC,
   parameter int GAP_CYC = `SS_GAP_CYC
) (
   input  wire logic core_clk_i,
   input  wire logic arst_n_i,
   input  wire logic rxd_i,
   output logic      txd_o,
   ss_uart_if.uart   u
);
   logic        rs1, rs2;
   logic        rx_busy, next_rx_busy;
   logic [15:0] rx_cnt, next_rx_cnt;
   logic [3:0]  rx_bit, next_rx_bit;
   logic [7:0]  rx_sh, next_rx_sh;
   logic        rx_vld, next_rx_vld;
   logic [19:0] gap, next_gap;
   logic        gap_end, next_gap_end;
   logic        tx_busy, next_tx_busy;
   logic [15:0] tx_cnt, next_tx_cnt;
   logic [3:0]  tx_bit, next_tx_bit;
   logic [9:0]  tx_sh, next_tx_sh;

   assign u.rx_data   = rx_sh;
   assign u.rx_valid  = rx_vld;
   assign u.frame_end = gap_end;
   assign u.tx_busy   = tx_busy;
   assign txd_o       = tx_sh[0];

   always_comb begin
      next_rx_busy = rx_busy;
      next_rx_cnt  = rx_cnt;
      next_rx_bit  = rx_bit;
      next_rx_sh   = rx_sh;
      next_rx_vld  = 1'b0;
      next_gap_end = 1'b0;
      next_gap     = gap;
      // Sample mid bit; start bit checked again against glitches
      if (!rx_busy) begin
         if (!rs2) begin
            next_rx_busy = 1'b1;
            next_rx_cnt  = 16'(BIT_CYC / 2);
            next_rx_bit  = 4'h0;
         end
      end else if (rx_cnt != 16'h0000) begin
         next_rx_cnt = rx_cnt - 16'h0001;
      end else begin
         next_rx_cnt = 16'(BIT_CYC - 1);
         next_rx_bit = rx_bit + 4'h1;
         if (rx_bit == 4'h0 && rs2) begin
            next_rx_busy = 1'b0;
         end else if (rx_bit == 4'h9) begin
            next_rx_busy = 1'b0;
            next_rx_vld  = rs2;
         end else if (rx_bit != 4'h0) begin
            next_rx_sh = {rs2, rx_sh[7:1]};
         end
      end
      // Silence of 3.5 characters closes a frame
      if (rx_busy || !rs2) begin
         next_gap = 20'h00000;
      end else if (gap != 20'(GAP_CYC)) begin
         next_gap     = gap + 20'h00001;
         next_gap_end = (gap == 20'(GAP_CYC - 1));
      end
   end

   always_comb begin
      next_tx_busy = tx_busy;
      next_tx_cnt  = tx_cnt;
      next_tx_bit  = tx_bit;
      next_tx_sh   = tx_sh;
      if (!tx_busy) begin
         if (u.tx_start) begin
            next_tx_busy = 1'b1;
            next_tx_sh   = {1'b1, u.tx_data, 1'b0};
            next_tx_cnt  = 16'(BIT_CYC - 1);
            next_tx_bit  = 4'h0;
         end
      end else if (tx_cnt != 16'h0000) begin
         next_tx_cnt = tx_cnt - 16'h0001;
      end else begin
         next_tx_cnt = 16'(BIT_CYC - 1);
         next_tx_sh  = {1'b1, tx_sh[9:1]};
         next_tx_bit = tx_bit + 4'h1;
         if (tx_bit == 4'h9) begin
            next_tx_busy = 1'b0;
         end
      end
   end

   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rs1     <= 1'b1;
         rs2     <= 1'b1;
         rx_busy <= 1'b0;
         rx_cnt  <= 16'h0000;
         rx_bit  <= 4'h0;
         rx_sh   <= 8'h00;
         rx_vld  <= 1'b0;
         gap     <= 20'h00000;
         gap_end <= 1'b0;
         tx_busy <= 1'b0;
         tx_cnt  <= 16'h0000;
         tx_bit  <= 4'h0;
         tx_sh   <= 10'h3FF;
      end else begin
         rs1     <= rxd_i;
         rs2     <= rs1;
         rx_busy <= next_rx_busy;
         rx_cnt  <= next_rx_cnt;
         rx_bit  <= next_rx_bit;
         rx_sh   <= next_rx_sh;
         rx_vld  <= next_rx_vld;
         gap     <= next_gap;
         gap_end <= next_gap_end;
         tx_busy <= next_tx_busy;
         tx_cnt  <= next_tx_cnt;
         tx_bit  <= next_tx_bit;
         tx_sh   <= next_tx_sh;
      end
   end
endmodule

// ==== rtl/ss_modbus_slave.sv ====
// Serial slave of the soft starter: frames, register map, stop sequencing.
// Assumes start-mode logic reports start_done_i and fault_evt_i on this clock.
`timescale 1ns/1ps
`include "ss_defines.svh"
module ss_modbus_slave #(
   parameter int BIT_CYC  = `SS_BIT_CYC,
   parameter int GAP_CYC  = `SS_GAP_CYC,
   parameter int UNIT_CYC = `SS_RAMP_UNIT_CYC
) (
   input  wire logic        core_clk_i,
   input  wire logic        arst_n_i,
   input  wire logic        rxd_i,
   output logic             txd_o,
   output logic             drv_en_n_o,
   input  wire logic [7:0]  slave_addr_i,
   input  wire logic [15:0] current_avg_i,
   input  wire logic [15:0] fault_code_i,
   input  wire logic        fault_evt_i,
   input  wire logic        start_done_i,
   output logic             bypass_on_o,
   output logic             thyristor_en_o,
   output logic [7:0]       out_volt_pct_o,
   output logic [15:0]      current_limit_o
);
   ss_uart_if u ();

   ss_uart #(.BIT_CYC(BIT_CYC), .GAP_CYC(GAP_CYC)) u_uart (
      .core_clk_i (core_clk_i),
      .arst_n_i   (arst_n_i),
      .rxd_i      (rxd_i),
      .txd_o      (txd_o),
      .u          (u.uart)
   );

   function automatic logic [15:0] crc_upd(input logic [15:0] c,
                                           input logic [7:0]  b);
      logic [15:0] x;
      x = c ^ {8'h00, b};
      for (int i = 0; i < 8; i++) begin
         x = x[0] ? ((x >> 1) ^ `SS_CRC_POLY) : (x >> 1);
      end
      return x;
   endfunction

   ss_pkg::ss_link_t  link, next_link;
   logic [7:0]  rx_buf [8];
   logic [7:0]  next_rx_buf [8];
   logic [3:0]  rx_n, next_rx_n;
   logic [15:0] rx_crc, next_rx_crc;
   logic [7:0]  tx_buf [8];
   logic [7:0]  next_tx_buf [8];
   logic [3:0]  tx_len, next_tx_len;
   logic [3:0]  tx_idx, next_tx_idx;
   logic [15:0] tx_crc, next_tx_crc;
   logic [7:0]  tx_data, next_tx_data;
   logic        tx_start, next_tx_start;
   logic        next_drv_en_n;
   logic [15:0] prm [`SS_PRM_NUM];
   logic [15:0] next_prm [`SS_PRM_NUM];

   logic [7:0]  req_fc;
   logic [15:0] req_reg, req_val, rd_word, status_word;
   logic [4:0]  prm_idx;
   logic        is_prm, rd_ok, wr_ok, frame_good;
   logic        cmd_start, cmd_stop, cmd_rst;

   ss_pkg::ss_motor_t ms, next_ms;
   logic        fault, next_fault;
   logic        bypass, next_bypass;
   logic        thy, next_thy;
   logic [7:0]  volt, next_volt;
   logic [15:0] cur_lim, next_cur_lim;
   logic [20:0] step, next_step;
   logic [15:0] units, next_units;
   logic [31:0] soft_lim;

   assign u.tx_data  = tx_data;
   assign u.tx_start = tx_start;

   assign req_fc   = rx_buf[1];
   assign req_reg  = {rx_buf[2], rx_buf[3]};
   assign req_val  = {rx_buf[4], rx_buf[5]};
   assign is_prm   = req_reg >= `SS_REG_PRM_FIRST &&
                     req_reg <= `SS_REG_PRM_LAST;
   assign prm_idx  = req_reg[4:0];
   assign rd_ok    = is_prm || (req_reg >= `SS_REG_STAT &&
                                req_reg <= `SS_REG_FAULT);
   assign wr_ok    = is_prm || req_reg == `SS_REG_CTRL;
   // Broadcast address 0 is never answered, so it is not taken either
   assign frame_good = u.frame_end && link == ss_pkg::SS_LK_RX &&
                       rx_n == `SS_LEN_REQ && rx_crc == 16'h0000 &&
                       rx_buf[0] == slave_addr_i &&
                       slave_addr_i != 8'h00;
   assign cmd_start = frame_good && req_fc == `SS_FC_WRITE &&
                      req_reg == `SS_REG_CTRL && req_val[`SS_CTL_START];
   assign cmd_stop  = frame_good && req_fc == `SS_FC_WRITE &&
                      req_reg == `SS_REG_CTRL && req_val[`SS_CTL_STOP];
   assign cmd_rst   = frame_good && req_fc == `SS_FC_WRITE &&
                      req_reg == `SS_REG_CTRL && req_val[`SS_CTL_RST];
   assign status_word = {12'h000, fault, ms == ss_pkg::SS_MS_SOFT,
                         ms == ss_pkg::SS_MS_RUNNING,
                         ms == ss_pkg::SS_MS_STARTING};

   always_comb begin
      case (req_reg)
         `SS_REG_STAT:  rd_word = status_word;
         `SS_REG_CURR:  rd_word = current_avg_i;
         `SS_REG_FAULT: rd_word = fault_code_i;
         default:       rd_word = prm[prm_idx];
      endcase
   end

   always_comb begin
      next_link     = link;
      next_rx_buf   = rx_buf;
      next_rx_n     = rx_n;
      next_rx_crc   = rx_crc;
      next_tx_buf   = tx_buf;
      next_tx_len   = tx_len;
      next_tx_idx   = tx_idx;
      next_tx_crc   = tx_crc;
      next_tx_data  = tx_data;
      next_tx_start = 1'b0;
      next_prm      = prm;
      // Half duplex: our own echo is not collected while sending
      if (link == ss_pkg::SS_LK_RX && u.rx_valid) begin
         if (rx_n < `SS_LEN_REQ) begin
            next_rx_buf[rx_n[2:0]] = u.rx_data;
         end
         if (rx_n != `SS_LEN_OVF) begin
            next_rx_n = rx_n + 4'h1;
         end
         next_rx_crc = crc_upd(rx_crc, u.rx_data);
      end
      if (u.frame_end) begin
         next_rx_n   = 4'h0;
         next_rx_crc = `SS_CRC_INIT;
      end
      if (frame_good) begin
         next_link      = ss_pkg::SS_LK_TX;
         next_tx_idx    = 4'h0;
         next_tx_crc    = `SS_CRC_INIT;
         next_tx_buf[0] = rx_buf[0];
         next_tx_buf[1] = req_fc | `SS_EXC_FLAG;
         next_tx_len    = `SS_LEN_EXC;
         case (req_fc)
            `SS_FC_READ: begin
               if (!rd_ok) begin
                  next_tx_buf[2] = `SS_EXC_ADDR;
               end else if (req_val != `SS_QTY_ONE) begin
                  next_tx_buf[2] = `SS_EXC_VALUE;
               end else begin
                  next_tx_buf[1] = req_fc;
                  next_tx_buf[2] = `SS_RD_BYTES;
                  next_tx_buf[3] = rd_word[15:8];
                  next_tx_buf[4] = rd_word[7:0];
                  next_tx_len    = `SS_LEN_RD;
               end
            end
            `SS_FC_WRITE: begin
               if (!wr_ok) begin
                  next_tx_buf[2] = `SS_EXC_ADDR;
               end else begin
                  for (int i = 0; i < 6; i++) begin
                     next_tx_buf[i] = rx_buf[i];
                  end
                  next_tx_len = `SS_LEN_ECHO;
                  if (is_prm) begin
                     next_prm[prm_idx] = req_val;
                  end
               end
            end
            default: begin
               next_tx_buf[2] = `SS_EXC_FUNC;
            end
         endcase
      end
      // One byte handed over per idle, then check low byte before high
      if (link == ss_pkg::SS_LK_TX && !u.tx_busy && !tx_start) begin
         if (tx_idx < tx_len + `SS_LEN_CRC) begin
            next_tx_start = 1'b1;
            next_tx_idx   = tx_idx + 4'h1;
            if (tx_idx < tx_len) begin
               next_tx_data = tx_buf[tx_idx[2:0]];
               next_tx_crc  = crc_upd(tx_crc, tx_buf[tx_idx[2:0]]);
            end else if (tx_idx == tx_len) begin
               next_tx_data = tx_crc[7:0];
            end else begin
               next_tx_data = tx_crc[15:8];
            end
         end else begin
            next_link = ss_pkg::SS_LK_RX;
         end
      end
      next_drv_en_n = next_link != ss_pkg::SS_LK_TX;
   end

   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         link       <= ss_pkg::SS_LK_RX;
         rx_n       <= 4'h0;
         rx_crc     <= `SS_CRC_INIT;
         tx_len     <= 4'h0;
         tx_idx     <= 4'h0;
         tx_crc     <= `SS_CRC_INIT;
         tx_data    <= 8'h00;
         tx_start   <= 1'b0;
         drv_en_n_o <= 1'b1;
         for (int i = 0; i < 8; i++) begin
            rx_buf[i] <= 8'h00;
            tx_buf[i] <= 8'h00;
         end
         for (int i = 0; i < `SS_PRM_NUM; i++) begin
            prm[i] <= 16'h0000;
         end
      end else begin
         link       <= next_link;
         rx_n       <= next_rx_n;
         rx_crc     <= next_rx_crc;
         tx_len     <= next_tx_len;
         tx_idx     <= next_tx_idx;
         tx_crc     <= next_tx_crc;
         tx_data    <= next_tx_data;
         tx_start   <= next_tx_start;
         drv_en_n_o <= next_drv_en_n;
         rx_buf     <= next_rx_buf;
         tx_buf     <= next_tx_buf;
         prm        <= next_prm;
      end
   end

   // Product kept 32 bits wide so large limits cannot wrap
   assign soft_lim = prm[`SS_PRM_SOFT_LIM] * prm[`SS_PRM_START_LIM]
                     / `SS_PCT_DIV;

   always_comb begin
      next_ms     = ms;
      next_fault  = fault;
      next_bypass = bypass;
      next_thy    = thy;
      next_volt   = volt;
      next_step   = step;
      next_units  = units;
      case (ms)
         ss_pkg::SS_MS_STOP: begin
            if (cmd_start && !fault) begin
               next_ms   = ss_pkg::SS_MS_STARTING;
               next_thy  = 1'b1;
               next_volt = prm[`SS_PRM_INIT_V][7:0];
            end
         end
         ss_pkg::SS_MS_STARTING: begin
            if (start_done_i) begin
               next_ms     = ss_pkg::SS_MS_RUNNING;
               next_bypass = 1'b1;
               next_thy    = 1'b0;
               next_volt   = `SS_FULL_V;
            end
         end
         ss_pkg::SS_MS_SOFT: begin
            next_step = step + 21'h000001;
            if (step == 21'(UNIT_CYC - 1)) begin
               next_step  = 21'h000000;
               next_units = units + 16'h0001;
               if (units + 16'h0001 >= prm[`SS_PRM_STOP_RAMP]) begin
                  next_units = 16'h0000;
                  next_volt  = volt - 8'h01;
                  if (volt - 8'h01 <= prm[`SS_PRM_INIT_V][7:0]) begin
                     next_ms   = ss_pkg::SS_MS_STOP;
                     next_thy  = 1'b0;
                     next_volt = 8'h00;
                  end
               end
            end
         end
         default: begin
         end
      endcase
      if (cmd_stop && (ms == ss_pkg::SS_MS_STARTING ||
                       ms == ss_pkg::SS_MS_RUNNING)) begin
         next_bypass = 1'b0;
         next_step   = 21'h000000;
         next_units  = 16'h0000;
         if (prm[`SS_PRM_STOP_RAMP] == 16'h0000) begin
            next_ms   = ss_pkg::SS_MS_STOP;
            next_thy  = 1'b0;
            next_volt = 8'h00;
         end else begin
            next_ms   = ss_pkg::SS_MS_SOFT;
            next_thy  = 1'b1;
            next_volt = `SS_FULL_V;
         end
      end
      if (cmd_rst) begin
         next_fault = 1'b0;
      end
      // A fault arriving with the reset command still wins
      if (fault_evt_i) begin
         next_fault  = 1'b1;
         next_ms     = ss_pkg::SS_MS_STOP;
         next_bypass = 1'b0;
         next_thy    = 1'b0;
         next_volt   = 8'h00;
      end
      next_cur_lim = (next_ms == ss_pkg::SS_MS_SOFT) ? soft_lim[15:0]
                                                     : prm[`SS_PRM_START_LIM];
   end

   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         ms      <= ss_pkg::SS_MS_STOP;
         fault   <= 1'b0;
         bypass  <= 1'b0;
         thy     <= 1'b0;
         volt    <= 8'h00;
         cur_lim <= 16'h0000;
         step    <= 21'h000000;
         units   <= 16'h0000;
      end else begin
         ms      <= next_ms;
         fault   <= next_fault;
         bypass  <= next_bypass;
         thy     <= next_thy;
         volt    <= next_volt;
         cur_lim <= next_cur_lim;
         step    <= next_step;
         units   <= next_units;
      end
   end

   assign bypass_on_o     = bypass;
   assign thyristor_en_o  = thy;
   assign out_volt_pct_o  = volt;
   assign current_limit_o = cur_lim;
endmodule

// ==== verification/ss_chk.sv ====
// Concurrent checks on the serial slave link pins and motor outputs.
// Assumes it is bound into ss_modbus_slave; one clock domain.
`timescale 1ns/1ps
module ss_chk (
   input wire logic       core_clk_i,
   input wire logic       arst_n_i,
   input wire logic       txd_o,
   input wire logic       drv_en_n_o,
   input wire logic       bypass_on_o,
   input wire logic       thyristor_en_o,
   input wire logic [7:0] out_volt_pct_o
);
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (!arst_n_i);
   a_tx_idle_high: assert property (drv_en_n_o |-> txd_o)
      else $error("txd low while driver off");
   a_drv_lead: assert property (
      $fell(drv_en_n_o) |-> txd_o ##1 txd_o)
      else $error("start bit too close to driver on");
   a_drv_tail: assert property ($rose(drv_en_n_o) |-> $past(txd_o))
      else $error("driver off before stop bit");
   a_path_excl: assert property (
      !(bypass_on_o && thyristor_en_o))
      else $error("bypass and thyristor both on");
   a_off_zero: assert property (
      !bypass_on_o && !thyristor_en_o |-> out_volt_pct_o == 8'h00)
      else $error("voltage with output off");
   a_bypass_full: assert property (
      bypass_on_o |-> out_volt_pct_o == 8'h64)
      else $error("bypass without full voltage");
   a_soft_entry: assert property (
      $fell(bypass_on_o) && thyristor_en_o |-> out_volt_pct_o == 8'h64)
      else $error("soft stop not from full voltage");
   a_ramp_step: assert property (
      thyristor_en_o && out_volt_pct_o < $past(out_volt_pct_o)
      |-> out_volt_pct_o == $past(out_volt_pct_o) - 8'h01)
      else $error("ramp step not one percent");
   a_run_entry: assert property (
      $rose(bypass_on_o) |-> $past(thyristor_en_o))
      else $error("run without start phase");
   c_soft_end: cover property ($fell(thyristor_en_o) && !bypass_on_o);
   c_run: cover property ($rose(bypass_on_o));
   c_reply: cover property ($fell(drv_en_n_o));
endmodule

// ==== verification/ss_mb_master.sv ====
// Bus master model: sends request frames, collects reply bytes in rq.
// Assumes an idle-high biased line and the slave's bit time.
`timescale 1ns/1ps
module ss_mb_master #(
   parameter int BIT_CYC = 16
) (
   input  wire logic core_clk_i,
   output logic      rxd_o,
   input  wire logic txd_i
);
   logic [7:0] rq[$];
   initial rxd_o = 1'b1;
   function automatic logic [15:0] crc(input logic [7:0] q[$]);
      logic [15:0] c;
      c = 16'hFFFF;
      foreach (q[i]) begin
         c ^= {8'h00, q[i]};
         repeat (8) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
      end
      return c;
   endfunction
   task automatic send(input logic [7:0] q[$], input logic bad);
      logic [15:0] c;
      logic [9:0]  w;
      c = crc(q) ^ {15'h0000, bad};
      q.push_back(c[7:0]);
      q.push_back(c[15:8]);
      foreach (q[i]) begin
         w = {1'b1, q[i], 1'b0};
         for (int b = 0; b < 10; b++) begin
            @(negedge core_clk_i) rxd_o <= w[b];
            repeat (BIT_CYC - 1) @(negedge core_clk_i);
         end
      end
   endtask
   // Reply ends after three idle bit times; lim bounds the first wait
   task automatic recv(input int lim);
      logic [7:0] d;
      int         t;
      rq.delete();
      forever begin
         for (t = 0; t < lim && txd_i !== 1'b0; t++) @(posedge core_clk_i);
         if (t >= lim) return;
         repeat (BIT_CYC / 2) @(posedge core_clk_i);
         for (int b = 0; b < 8; b++) begin
            repeat (BIT_CYC) @(posedge core_clk_i);
            d[b] = txd_i;
         end
         repeat (BIT_CYC) @(posedge core_clk_i);
         rq.push_back(d);
         lim = 3 * BIT_CYC;
      end
   endtask
endmodule

// ==== verification/tb.sv ====
// Self-checking bench: master frames into the slave, replies and motor
// outputs compared. Assumes shortened bit, gap and ramp timing.
`timescale 1ns/1ps
module tb;
   localparam int BIT = 16;
   localparam int GAP = 600;
   logic        core_clk_i = 1'b0;
   logic        arst_n_i = 1'b0;
   logic        rxd_i;
   logic        txd_o;
   logic        drv_en_n_o;
   logic [15:0] current_avg_i = 16'h092E;
   logic [15:0] fault_code_i = 16'h0004;
   logic [7:0]  slave_addr_i = 8'h02;
   logic        fault_evt_i = 1'b0;
   logic        start_done_i = 1'b0;
   logic        bypass_on_o;
   logic        thyristor_en_o;
   logic [7:0]  out_volt_pct_o;
   logic [15:0] current_limit_o;
   logic [25:0] outs;
   int          fails = 0;
   int          check_count = 0;
   int          soft_cyc = 0;
   // Row: function, register, value, reply kind, expected code or data
   logic [63:0] rows [14] = '{64'h03_0003_0001_02_092E,
      64'h03_0004_0001_02_0004, 64'h06_0002_0005_00_0002,
      64'h06_0005_0001_00_0002, 64'h03_0113_0001_00_0002,
      64'h08_0080_000D_00_0001, 64'h03_0100_0002_00_0003,
      64'h06_0112_BEEF_01_0000, 64'h03_0112_0001_02_BEEF,
      64'h06_0103_0032_01_0000, 64'h06_0106_00C8_01_0000,
      64'h06_010F_0032_01_0000, 64'h06_0102_0020_01_0000,
      64'h06_0001_0001_01_0000};
   assign outs = {bypass_on_o, thyristor_en_o, out_volt_pct_o,
                  current_limit_o};
   always #4 core_clk_i = ~core_clk_i;
   always @(posedge core_clk_i)
      soft_cyc <= bypass_on_o ? 0 : soft_cyc + int'(thyristor_en_o);
   ss_modbus_slave #(.BIT_CYC(BIT), .GAP_CYC(GAP), .UNIT_CYC(4)) dut_u (
      .core_clk_i, .arst_n_i, .rxd_i, .txd_o, .drv_en_n_o,
      .slave_addr_i, .current_avg_i, .fault_code_i, .fault_evt_i,
      .start_done_i, .bypass_on_o, .thyristor_en_o, .out_volt_pct_o,
      .current_limit_o);
   ss_mb_master #(.BIT_CYC(BIT)) master_u (
      .core_clk_i, .rxd_o(rxd_i), .txd_i(txd_o));
   task automatic chk(input logic [79:0] g, input logic [79:0] e);
      check_count++;
      if (g !== e) begin
         fails++;
         $display("FAIL %0t got %h exp %h", $time, g, e);
      end
   endtask
   function automatic logic [79:0] pk(input logic [7:0] q[$]);
      logic [79:0] r;
      r = 80'(q.size());
      foreach (q[i]) r = {r[71:0], q[i]};
      return r;
   endfunction
   task automatic pulse(ref logic s);
      @(negedge core_clk_i) s = 1'b1;
      @(negedge core_clk_i) s = 1'b0;
      repeat (2) @(negedge core_clk_i);
   endtask
   task automatic xact(input logic [7:0] a, input logic bad,
                       input logic [63:0] r);
      logic [7:0]  q[$];
      logic [7:0]  x[$];
      logic [15:0] c;
      q = {a, r[63:56], r[55:48], r[47:40], r[39:32], r[31:24]};
      case (r[23:16])
         8'h00: x = {a, r[63:56] | 8'h80, r[7:0]};
         8'h01: x = q;
         8'h02: x = {a, r[63:56], 8'h02, r[15:8], r[7:0]};
         default: x = {};
      endcase
      c = master_u.crc(x);
      if (x.size() > 0) x = {x, c[7:0], c[15:8]};
      master_u.send(q, bad);
      master_u.recv(GAP + 200);
      chk(pk(master_u.rq), pk(x));
   endtask
   task automatic print_verdict();
      if (fails == 0 && check_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   initial begin
      repeat (12) @(negedge core_clk_i);
      chk(80'({txd_o, drv_en_n_o, outs}), 80'h0C00_0000);
      arst_n_i = 1'b1;
      repeat (700) @(negedge core_clk_i);
      foreach (rows[i]) xact(8'h02, 1'b0, rows[i]);
      chk(80'(outs), 80'({2'b01, 8'h32, 16'h00C8}));
      pulse(start_done_i);
      chk(80'(outs), 80'({2'b10, 8'h64, 16'h00C8}));
      xact(8'h02, 1'b0, 64'h03_0002_0001_02_0002);
      xact(8'h02, 1'b0, 64'h06_0001_0002_01_0000);
      chk(80'({outs[25:24], outs[15:0]}), 80'({2'b01, 16'h0064}));
      xact(8'h02, 1'b0, 64'h03_0002_0001_02_0004);
      for (int t = 0; t < 9000 && thyristor_en_o; t++) @(negedge core_clk_i);
      chk(80'(outs), 80'({2'b00, 8'h00, 16'h00C8}));
      chk(80'((soft_cyc + 8) / 128), 80'h32);
      xact(8'h02, 1'b0, 64'h06_0102_0000_01_0000);
      xact(8'h02, 1'b0, 64'h06_0001_0001_01_0000);
      pulse(start_done_i);
      xact(8'h02, 1'b0, 64'h06_0001_0002_01_0000);
      chk(80'(outs), 80'({2'b00, 8'h00, 16'h00C8}));
      pulse(fault_evt_i);
      xact(8'h02, 1'b0, 64'h03_0002_0001_02_0008);
      xact(8'h02, 1'b0, 64'h06_0001_0001_01_0000);
      chk(80'(thyristor_en_o), 80'h0);
      xact(8'h02, 1'b0, 64'h06_0001_0004_01_0000);
      xact(8'h05, 1'b0, 64'h03_0002_0001_03_0000);
      xact(8'h02, 1'b1, 64'h06_0001_0001_03_0000);
      // Station address 0 must neither answer nor act
      @(negedge core_clk_i) slave_addr_i = 8'h00;
      xact(8'h00, 1'b0, 64'h06_0001_0001_03_0000);
      @(negedge core_clk_i) slave_addr_i = 8'h02;
      xact(8'h02, 1'b0, 64'h03_0002_0001_02_0000);
      print_verdict();
   end
   // Limit sits above the longest expected run of frames and ramp
   initial begin
      repeat (95000) @(posedge core_clk_i);
      fails++;
      print_verdict();
   end
endmodule
bind ss_modbus_slave ss_chk chk_u (.core_clk_i, .arst_n_i, .txd_o,
   .drv_en_n_o, .bypass_on_o, .thyristor_en_o, .out_volt_pct_o);
